// >>> src/uart_ctl_pkg.sv
// Package of register offsets, field positions, reset values and state
// types for the serial port control and interrupt block.
// Assumes a single 40 MHz clock and 32-entry FIFOs outside the block.
package uart_ctl_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the peripheral bus)
  // ==========================================================================
  localparam logic [7:0] OFS_PORT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FIFO_LEVEL = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_IRQ_RAW = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASKED = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;

  // ==========================================================================
  // Port control fields
  // ==========================================================================
  localparam int CR_CLEAR_SEND_FLOW_ENABLE = 15;
  localparam int CR_REQUEST_SEND_FLOW_ENABLE = 14;
  localparam int CR_REQUEST_SEND = 11;
  localparam int CR_TERMINAL_READY = 10;
  localparam int CR_RECEIVER_ENABLE = 9;
  localparam int CR_TRANSMITTER_ENABLE = 8;
  localparam int CR_INFRARED_LOW_POWER_SELECT = 2;
  localparam int CR_INFRARED_ENABLE = 1;
  localparam int CR_PORT_ENABLE = 0;
  localparam logic [15:0] CR_WRITE_MASK = 16'hcf07;
  localparam logic [15:0] CR_RESET = 16'h0000;

  // ==========================================================================
  // Level select fields and interrupt source positions
  // ==========================================================================
  localparam int LVL_RX_LSB = 3;
  localparam int LVL_TX_LSB = 0;
  localparam logic [5:0] LVL_RESET = 6'h00;
  localparam logic [10:0] MASK_RESET = 11'h000;
  localparam int IRQ_OVERRUN = 10;
  localparam int IRQ_BREAK = 9;
  localparam int IRQ_PARITY = 8;
  localparam int IRQ_FRAMING = 7;
  localparam int IRQ_RX_TIMEOUT = 6;
  localparam int IRQ_TX_LEVEL = 5;
  localparam int IRQ_RX_LEVEL = 4;
  localparam int IRQ_MODEM_LSB = 0;

  // ==========================================================================
  // Counts
  // ==========================================================================
  localparam logic [8:0] RX_TIMEOUT_TICKS = 9'h1ff;
  localparam logic [3:0] TICKS_PER_BIT_LAST = 4'hf;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [1:0] IR_LP_PULSE_LAST = 2'h2;
  localparam logic [3:0] DATA_BITS_LAST = 4'h7;
  localparam int TX_STAGE_DEPTH = 4;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_STOP = 2'b10
  } tx_state_t;

  // Trigger point in entries of a 32-entry FIFO; reserved codes act as 7/8.
  function automatic logic [5:0] fill_threshold(input logic [2:0] sel);
    case (sel)
      3'h0: fill_threshold = 6'h04;
      3'h1: fill_threshold = 6'h08;
      3'h2: fill_threshold = 6'h10;
      3'h3: fill_threshold = 6'h18;
      default: fill_threshold = 6'h1c;
    endcase
  endfunction

endpackage

// >>> src/stage_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset; DEPTH power of 2.
`timescale 1ns/1ps
`default_nettype none
module stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t q_reg;
  fifo_state_t q_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign o_in_ready = (q_reg.count != (AW+1)'(DEPTH));
  assign o_out_valid = (q_reg.count != '0);
  assign o_out_data = mem[q_reg.rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    q_next = q_reg;
    if (push)
      q_next.wr_ptr = q_reg.wr_ptr + 1'b1;
    if (pop)
      q_next.rd_ptr = q_reg.rd_ptr + 1'b1;
    if (push && !pop)
      q_next.count = q_reg.count + 1'b1;
    else if (pop && !push)
      q_next.count = q_reg.count - 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  // The array holds data only, so it needs no reset.
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[q_reg.wr_ptr] <= i_in_data;
  end
endmodule // stage_fifo
`default_nettype wire

// >>> src/uart_ctl.sv
// Control and interrupt logic of a serial port with infrared encoding and
// modem lines, plus a small character transmitter fed through a staging FIFO.
// Assumes the receive shifter, the 32-entry FIFOs and the tick dividers are
// outside; their counts, events and ticks arrive synchronous to i_clk.
//
// Summary of operation
// - With clear-send flow enabled outside infrared mode, no character starts until clear-send asserted.
// - With request-send flow enabled, request-send follows receive FIFO space.
// - Without request-send flow, request-send pin is the inverse of control bit 11.
// - Terminal-ready pin is the inverse of control bit 10.
// - Receiver enable gates reception; a character under way completes.
// - Transmitter enable gates sending; a character under way completes.
// - Infrared zero is a 3/16 bit pulse, or three low-power ticks.
// - Infrared mode holds serial out at 1 and ignores receive and modem pins.
// - Infrared disabled keeps infrared out at 0 and ignores its input.
// - Port enable gates all traffic; a character under way completes, but infrared out drops to 0 at once.
// - Receive level codes 0-4 trigger at 1/8..7/8 full or more.
// - Transmit level codes 0-4 trigger at 1/8..7/8 full or less.
// - Level interrupts fire on crossing the threshold, not on sitting past it.
// - Mask register holds one read/write bit per source, bits 10 to 0.
// - Raw and masked status share the same eleven-source bit order.
// - Break, parity and framing flags stay set until cleared by write.
// - Overrun is set by its event and clears on a receive FIFO read or a clear write.
// - Status reads zero after reset, except modem bits for pins already asserted.
// - Clear register is write-only; ones clear, zeros do nothing.
// - Receive timeout rises 511 oversample ticks after unread data stored.
`timescale 1ns/1ps
`default_nettype none
module uart_ctl
  import uart_ctl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_oversample_tick,
  input wire logic i_low_power_ir_tick,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [5:0] i_tx_fifo_count,
  input wire logic [5:0] i_rx_fifo_count,
  input wire logic i_rx_fifo_write,
  input wire logic i_rx_fifo_read,
  input wire logic i_rx_busy,
  input wire logic i_break_event,
  input wire logic i_parity_event,
  input wire logic i_framing_event,
  input wire logic i_overrun_event,
  input wire logic i_rxd_pin,
  input wire logic i_infrared_rx_pin,
  input wire logic i_clear_send_in_pin_n,
  input wire logic i_dsr_pin_n,
  input wire logic i_dcd_pin_n,
  input wire logic i_ring_pin_n,
  output logic o_rx_line,
  output logic o_rx_enable,
  output logic o_txd_pin,
  output logic o_infrared_tx_pin,
  output logic o_rts_pin_n,
  output logic o_dtr_pin_n,
  output logic o_irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [15:0] ctrl;
    logic [5:0] lvl;
    logic [10:0] mask;
    logic [10:0] flags;
    logic [5:0] rx_prev;
    logic [5:0] tx_prev;
    logic [8:0] tmo_cnt;
    logic [3:0] modem_prev;
    logic rx_gate;
    tx_state_t tx_state;
    logic [3:0] tick;
    logic [3:0] bit_idx;
    logic [7:0] shift;
    logic [1:0] lp_cnt;
    logic lp_on;
    logic txd;
    logic ir_out;
    logic rts_n;
    logic dtr_n;
    logic irq;
    logic [31:0] rdata;
  } state_t;

  state_t q_reg;
  state_t q_next;

  logic [7:0] stage_data;
  logic stage_valid;
  logic stage_take;
  logic wr_en;
  logic rd_en;
  logic ir_mode;
  logic port_on;
  logic cts_ok;
  logic bit_end;
  logic line_bit;
  logic [3:0] modem_now;
  logic [10:0] raw;
  logic [10:0] masked;
  logic [10:0] clear_bits;
  logic [5:0] rx_thr;
  logic [5:0] tx_thr;

  // Characters wait here so the bus side never stalls mid-character.
  stage_fifo #(
    .WIDTH(8),
    .DEPTH(TX_STAGE_DEPTH)
  ) u_stage (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_data(i_tx_data),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .o_out_data(stage_data),
    .o_out_valid(stage_valid),
    .i_out_ready(stage_take)
  );

  // ==========================================================================
  // Decode
  // ==========================================================================
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  assign ir_mode = q_reg.ctrl[CR_INFRARED_ENABLE];
  assign port_on = q_reg.ctrl[CR_PORT_ENABLE];
  // Modem pins are ignored in infrared mode; clear-send then counts as
  // asserted, so flow control cannot lock the transmitter forever.
  assign modem_now = ir_mode ? q_reg.modem_prev :
    {~i_dsr_pin_n, ~i_dcd_pin_n, ~i_clear_send_in_pin_n, ~i_ring_pin_n};
  assign cts_ok = !q_reg.ctrl[CR_CLEAR_SEND_FLOW_ENABLE] || ir_mode ||
    !i_clear_send_in_pin_n;
  assign stage_take = (q_reg.tx_state == TX_IDLE) && i_oversample_tick &&
    stage_valid && port_on && q_reg.ctrl[CR_TRANSMITTER_ENABLE] && cts_ok;
  assign bit_end = i_oversample_tick && (q_reg.tick == TICKS_PER_BIT_LAST);
  assign rx_thr = fill_threshold(q_reg.lvl[LVL_RX_LSB +: 3]);
  assign tx_thr = fill_threshold(q_reg.lvl[LVL_TX_LSB +: 3]);
  assign raw = q_reg.flags;
  assign masked = raw & q_reg.mask;
  assign clear_bits = (wr_en && i_paddr == OFS_IRQ_CLEAR) ?
    i_pwdata[10:0] : 11'h000;

  always_comb
  begin
    case (q_reg.tx_state)
      TX_START: line_bit = 1'b0;
      TX_DATA: line_bit = q_reg.shift[0];
      default: line_bit = 1'b1;
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    q_next = q_reg;

    // Registers written by software.
    if (wr_en && i_paddr == OFS_PORT_CONTROL)
      q_next.ctrl = i_pwdata[15:0] & CR_WRITE_MASK;
    if (wr_en && i_paddr == OFS_FIFO_LEVEL)
      q_next.lvl = i_pwdata[5:0];
    if (wr_en && i_paddr == OFS_IRQ_MASK)
      q_next.mask = i_pwdata[10:0];

    // Sticky flags: clear first so a same-cycle event wins.
    q_next.flags = q_reg.flags & ~clear_bits;
    if (i_rx_fifo_read)
      q_next.flags[IRQ_OVERRUN] = 1'b0;
    if (i_overrun_event)
      q_next.flags[IRQ_OVERRUN] = 1'b1;
    if (i_break_event)
      q_next.flags[IRQ_BREAK] = 1'b1;
    if (i_parity_event)
      q_next.flags[IRQ_PARITY] = 1'b1;
    if (i_framing_event)
      q_next.flags[IRQ_FRAMING] = 1'b1;
    if (q_reg.rx_prev < rx_thr && i_rx_fifo_count >= rx_thr)
      q_next.flags[IRQ_RX_LEVEL] = 1'b1;
    if (q_reg.tx_prev > tx_thr && i_tx_fifo_count <= tx_thr)
      q_next.flags[IRQ_TX_LEVEL] = 1'b1;
    q_next.flags[IRQ_MODEM_LSB +: 4] = q_next.flags[IRQ_MODEM_LSB +: 4] |
      (modem_now ^ q_reg.modem_prev);
    q_next.rx_prev = i_rx_fifo_count;
    q_next.tx_prev = i_tx_fifo_count;
    q_next.modem_prev = modem_now;

    // Timeout restarts on any FIFO traffic and stops at its terminal count.
    if (i_rx_fifo_write || i_rx_fifo_read || i_rx_fifo_count == 6'h00)
      q_next.tmo_cnt = 9'h000;
    else if (i_oversample_tick && q_reg.tmo_cnt != RX_TIMEOUT_TICKS)
    begin
      q_next.tmo_cnt = q_reg.tmo_cnt + 9'h001;
      if (q_next.tmo_cnt == RX_TIMEOUT_TICKS)
        q_next.flags[IRQ_RX_TIMEOUT] = 1'b1;
    end

    // Receiver gate only drops between characters.
    if (!i_rx_busy)
      q_next.rx_gate = port_on && q_reg.ctrl[CR_RECEIVER_ENABLE];

    // Character transmitter; a started character always runs to its stop bit.
    case (q_reg.tx_state)
      TX_IDLE:
      begin
        if (stage_take)
        begin
          q_next.tx_state = TX_START;
          q_next.shift = stage_data;
          q_next.tick = 4'h0;
          q_next.lp_on = 1'b1;
          q_next.lp_cnt = 2'h0;
        end
      end
      TX_START, TX_DATA, TX_STOP:
      begin
        if (i_oversample_tick)
          q_next.tick = q_reg.tick + 4'h1;
        if (bit_end)
        begin
          q_next.lp_on = 1'b1;
          q_next.lp_cnt = 2'h0;
          if (q_reg.tx_state == TX_START)
          begin
            q_next.tx_state = TX_DATA;
            q_next.bit_idx = 4'h0;
          end
          else if (q_reg.tx_state == TX_DATA)
          begin
            q_next.shift = {1'b1, q_reg.shift[7:1]};
            q_next.bit_idx = q_reg.bit_idx + 4'h1;
            if (q_reg.bit_idx == DATA_BITS_LAST)
              q_next.tx_state = TX_STOP;
          end
          else
            q_next.tx_state = TX_IDLE;
        end
      end
      default:
        q_next.tx_state = TX_IDLE;
    endcase
    if (i_low_power_ir_tick && q_reg.lp_on && !bit_end && !stage_take)
    begin
      if (q_reg.lp_cnt == IR_LP_PULSE_LAST)
        q_next.lp_on = 1'b0;
      else
        q_next.lp_cnt = q_reg.lp_cnt + 2'h1;
    end

    // Pins.
    q_next.txd = ir_mode ? 1'b1 : line_bit;
    if (!ir_mode || !port_on || line_bit)
      q_next.ir_out = 1'b0;
    else if (q_reg.ctrl[CR_INFRARED_LOW_POWER_SELECT])
      q_next.ir_out = q_reg.lp_on;
    else
      q_next.ir_out = (q_reg.tick < IR_PULSE_TICKS);
    if (q_reg.ctrl[CR_REQUEST_SEND_FLOW_ENABLE])
      q_next.rts_n = (i_rx_fifo_count >= rx_thr);
    else
      q_next.rts_n = !q_reg.ctrl[CR_REQUEST_SEND];
    q_next.dtr_n = !q_reg.ctrl[CR_TERMINAL_READY];
    q_next.irq = |masked;

    // Read data is captured in the setup phase and held through access.
    if (rd_en)
    begin
      case (i_paddr)
        OFS_PORT_CONTROL: q_next.rdata = {16'h0000, q_reg.ctrl};
        OFS_FIFO_LEVEL: q_next.rdata = {26'h000_0000, q_reg.lvl};
        OFS_IRQ_MASK: q_next.rdata = {21'h00_0000, q_reg.mask};
        OFS_IRQ_RAW: q_next.rdata = {21'h00_0000, raw};
        OFS_IRQ_MASKED: q_next.rdata = {21'h00_0000, masked};
        default: q_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q_reg <= '0;
      q_reg.ctrl <= CR_RESET;
      q_reg.lvl <= LVL_RESET;
      q_reg.mask <= MASK_RESET;
      q_reg.txd <= 1'b1;
      q_reg.rts_n <= 1'b1;
      q_reg.dtr_n <= 1'b1;
    end
    else
      q_reg <= q_next;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_prdata = q_reg.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_rx_line = q_reg.ctrl[CR_INFRARED_ENABLE] ? ~i_infrared_rx_pin :
    i_rxd_pin;
  assign o_rx_enable = q_reg.rx_gate;
  assign o_txd_pin = q_reg.txd;
  assign o_infrared_tx_pin = q_reg.ir_out;
  assign o_rts_pin_n = q_reg.rts_n;
  assign o_dtr_pin_n = q_reg.dtr_n;
  assign o_irq = q_reg.irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  rts_manual_a: assert property (
    !q_reg.ctrl[CR_REQUEST_SEND_FLOW_ENABLE]
    |=> o_rts_pin_n == !$past(q_reg.ctrl[CR_REQUEST_SEND]))
    else $error("request-send pin not the inverse of its bit");
  dtr_pin_a: assert property (
    ##1 o_dtr_pin_n == !$past(q_reg.ctrl[CR_TERMINAL_READY]))
    else $error("terminal-ready pin not the inverse of its bit");
  cts_hold_a: assert property (
    (q_reg.tx_state == TX_IDLE && !ir_mode && i_clear_send_in_pin_n &&
     q_reg.ctrl[CR_CLEAR_SEND_FLOW_ENABLE]) |=> q_reg.tx_state == TX_IDLE)
    else $error("character started without clear-send");
  ir_idle_a: assert property (
    !ir_mode |=> !o_infrared_tx_pin)
    else $error("infrared output active while disabled");
  txd_mark_a: assert property (
    ir_mode |=> o_txd_pin)
    else $error("serial output not marking in infrared mode");
  irq_combine_a: assert property (
    ##1 o_irq == $past(|(q_reg.flags & q_reg.mask)))
    else $error("interrupt output disagrees with masked status");
  err_sticky_a: assert property (
    (q_reg.flags[IRQ_BREAK] && !clear_bits[IRQ_BREAK])
    |=> q_reg.flags[IRQ_BREAK])
    else $error("break flag lost without a clear");
  timeout_count_a: assert property (
    $rose(q_reg.flags[IRQ_RX_TIMEOUT])
    |-> $past(q_reg.tmo_cnt) == 9'h1fe && q_reg.tmo_cnt == RX_TIMEOUT_TICKS)
    else $error("receive timeout raised at the wrong count");
  rx_cross_a: assert property (
    $rose(q_reg.flags[IRQ_RX_LEVEL]) |-> $past(q_reg.rx_prev) < $past(rx_thr))
    else $error("receive level flag set without a crossing");
  tx_finish_a: assert property (
    (q_reg.tx_state == TX_DATA && !port_on) |=> q_reg.tx_state != TX_IDLE)
    else $error("character abandoned before its stop bit");

  tx_char_c: cover property (q_reg.tx_state == TX_STOP && bit_end);
  timeout_c: cover property ($rose(q_reg.flags[IRQ_RX_TIMEOUT]));
  rx_level_c: cover property ($rose(q_reg.flags[IRQ_RX_LEVEL]));
  ir_pulse_c: cover property ($rose(o_infrared_tx_pin));

endmodule // uart_ctl
`default_nettype wire

// >>> sim/peer_model.sv
// Peer serial port model: decodes the serial output and drives clear-send.
// Assumes oversample ticks from the bench and 1 start, 8 data, 1 stop bit.
`timescale 1ns/1ps
`default_nettype none
module peer_model (
  input wire logic i_clk,
  input wire logic i_tick,
  input wire logic i_txd,
  input wire logic i_allow,
  output logic o_clear_send_n,
  output logic [7:0] o_byte,
  output logic [7:0] o_count
);
  // ==========================================================================
  // Flow control and frame decoding
  // ==========================================================================
  logic [7:0] shift;

  // Clear-send is active low; the peer asserts it only while it can accept.
  assign o_clear_send_n = ~i_allow;

  task automatic ticks(input int n);
    for (int i = 0; i < n; i++)
      do @(posedge i_clk); while (i_tick !== 1'b1);
  endtask

  initial
  begin
    o_count = 8'h00;
    o_byte = 8'h00;
    shift = 8'h00;
    forever
    begin
      @(negedge i_txd);
      ticks(8);
      for (int b = 0; b < 8; b++)
      begin
        ticks(16);
        shift = {i_txd, shift[7:1]};
      end
      ticks(16);
      // A frame without a good stop bit is not delivered.
      if (i_txd === 1'b1)
      begin
        o_byte = shift;
        o_count = o_count + 8'h01;
      end
    end
  end
endmodule // peer_model
`default_nettype wire

// >>> sim/uart_ctl_tb.sv
// Self-checking testbench for the serial port control and interrupt block.
// Assumes the peer model on the serial side and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module uart_ctl_tb
  import uart_ctl_pkg::*;
();
  logic clk, rst_n, psel, penable, pwrite, tick, tx_valid;
  logic rx_wr, rx_rd, brk, par, frm, ovr, allow, cs_n;
  logic [7:0] paddr, tx_data, pbyte, pcount;
  logic [31:0] pwdata, prdata;
  logic [5:0] tx_cnt, rx_cnt;
  logic [2:0] modem_n;
  logic pready, pslverr, tx_ready, rx_line, rx_en, txd, ir_tx, rts_n;
  logic dtr_n, irq, rxd, ir_rx, rx_busy, lp_tick;
  int fails, num_checks, cycles;

  uart_ctl u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_oversample_tick(tick),
    .i_low_power_ir_tick(lp_tick), .i_tx_data(tx_data),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .i_tx_fifo_count(tx_cnt), .i_rx_fifo_count(rx_cnt),
    .i_rx_fifo_write(rx_wr), .i_rx_fifo_read(rx_rd), .i_rx_busy(rx_busy),
    .i_break_event(brk), .i_parity_event(par), .i_framing_event(frm),
    .i_overrun_event(ovr), .i_rxd_pin(rxd), .i_infrared_rx_pin(ir_rx),
    .i_clear_send_in_pin_n(cs_n), .i_dsr_pin_n(modem_n[2]),
    .i_dcd_pin_n(modem_n[1]), .i_ring_pin_n(modem_n[0]),
    .o_rx_line(rx_line), .o_rx_enable(rx_en), .o_txd_pin(txd),
    .o_infrared_tx_pin(ir_tx), .o_rts_pin_n(rts_n), .o_dtr_pin_n(dtr_n),
    .o_irq(irq));
  peer_model u_peer (.i_clk(clk), .i_tick(tick), .i_txd(txd),
    .i_allow(allow), .o_clear_send_n(cs_n), .o_byte(pbyte),
    .o_count(pcount));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Two cycles per tick keeps the 511-tick timeout short to simulate.
  always @(posedge clk) tick <= #1 ~tick;

  // ==========================================================================
  // Bus and check tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    step(1);
    {psel, pwrite, paddr, pwdata} = {1'b1, 1'b1, a, d};
    step(1);
    penable = 1'b1;
    step(1);
    {psel, penable, pwrite} = 3'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] v;
    step(1);
    {psel, pwrite, paddr} = {1'b1, 1'b0, a};
    step(1);
    penable = 1'b1;
    @(posedge clk);
    v = prdata;
    #1;
    {psel, penable} = 2'h0;
    chk(v & m, e);
  endtask
  task automatic send(input logic [7:0] d);
    step(1);
    {tx_data, tx_valid} = {d, 1'b1};
    do @(posedge clk); while (tx_ready !== 1'b1);
    #1;
    tx_valid = 1'b0;
  endtask
  task automatic wait_peer(input logic [7:0] n);
    for (int i = 0; i < 1000 && pcount !== n; i++)
      step(1);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    // Modem status after reset follows the pins, so raw bits 3..0 are free.
    for (int i = 0; i < 5; i++)
      rchk(8'(i * 4), (i == 3) ? 32'hffff_fff0 : 32'hffff_ffff,
        32'h0000_0000);
    chk({pready, pslverr, rx_en, rts_n, dtr_n, txd, ir_tx, irq, tx_ready},
      9'h139);
  endtask
  task automatic t_ctrl();
    logic pb;
    wr(OFS_PORT_CONTROL, 32'h0000_0c00);
    step(1);
    chk({rts_n, dtr_n}, 2'h0);
    wr(OFS_PORT_CONTROL, 32'h0000_0800);
    step(1);
    chk({rts_n, dtr_n}, 2'h1);
    wr(OFS_PORT_CONTROL, 32'h0000_4000);
    step(1);
    chk(rts_n, 1'b0);
    rx_cnt = 6'h04;
    step(2);
    chk(rts_n, 1'b1);
    rx_cnt = 6'h00;
    wr(OFS_PORT_CONTROL, 32'hffff_ffff);
    rchk(OFS_PORT_CONTROL, 32'hffff_ffff, {16'h0000, CR_WRITE_MASK});
    chk(txd, 1'b1);
    chk(rx_en, 1'b1);
    pb = rx_line;
    rxd = 1'b0;
    step(1);
    chk(rx_line, pb);
    {rx_busy, ir_rx} = 2'b10;
    wr(OFS_PORT_CONTROL, 32'h0000_0000);
    step(2);
    chk(rx_en, 1'b1);
    rx_busy = 1'b0;
    step(2);
    chk({rx_en, rx_line}, 2'h0);
    {rxd, ir_rx} = 2'b11;
    step(1);
    chk(rx_line, 1'b1);
    wr(OFS_IRQ_CLEAR, 32'h0000_07ff);
  endtask
  task automatic t_status();
    wr(OFS_IRQ_MASK, 32'hffff_ffff);
    rchk(OFS_IRQ_MASK, 32'hffff_ffff, 32'h0000_07ff);
    rchk(8'h40, 32'hffff_ffff, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0380);
    {brk, par, frm} = 3'h7;
    step(1);
    {brk, par, frm} = 3'h0;
    step(2);
    rchk(OFS_IRQ_RAW, 32'hffff_ffff, 32'h0000_0380);
    chk(irq, 1'b1);
    wr(OFS_IRQ_CLEAR, 32'h0000_0000);
    rchk(OFS_IRQ_MASKED, 32'hffff_ffff, 32'h0000_0380);
    wr(OFS_IRQ_CLEAR, 32'h0000_0100);
    rchk(OFS_IRQ_RAW, 32'hffff_ffff, 32'h0000_0280);
    wr(OFS_IRQ_MASK, 32'h0000_0100);
    step(2);
    chk(irq, 1'b0);
    {ovr, modem_n} = {1'b1, 3'h3};
    step(1);
    ovr = 1'b0;
    wr(OFS_IRQ_CLEAR, 32'h0000_0380);
    rchk(OFS_IRQ_RAW, 32'hffff_ffff, 32'h0000_0408);
    rx_rd = 1'b1;
    step(1);
    rx_rd = 1'b0;
    rchk(OFS_IRQ_RAW, 32'hffff_ffff, 32'h0000_0008);
    wr(OFS_IRQ_CLEAR, 32'h0000_07ff);
  endtask
  task automatic t_level();
    logic [5:0] thr [5] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h1c};
    for (int s = 0; s < 5; s++)
    begin
      wr(OFS_FIFO_LEVEL, 32'(s * 9));
      {rx_cnt, tx_cnt} = {thr[s] - 6'h01, thr[s] + 6'h01};
      step(2);
      rchk(OFS_IRQ_RAW, 32'h0000_0030, 32'h0000_0000);
      {rx_cnt, tx_cnt} = {thr[s], thr[s]};
      step(2);
      rchk(OFS_IRQ_RAW, 32'h0000_0030, 32'h0000_0030);
      wr(OFS_IRQ_CLEAR, 32'h0000_0030);
      rchk(OFS_IRQ_RAW, 32'h0000_0030, 32'h0000_0000);
    end
    {rx_cnt, rx_wr} = {6'h01, 1'b1};
    step(1);
    rx_wr = 1'b0;
    step(990);
    rchk(OFS_IRQ_RAW, 32'h0000_0040, 32'h0000_0000);
    step(60);
    rchk(OFS_IRQ_RAW, 32'h0000_0040, 32'h0000_0040);
    rx_cnt = 6'h00;
  endtask
  task automatic t_tx();
    int hi;
    logic mark;
    wr(OFS_PORT_CONTROL, 32'h0000_0101);
    send(8'ha5);
    wait_peer(8'h01);
    chk(pbyte, 8'ha5);
    chk(ir_tx, 1'b0);
    allow = 1'b0;
    wr(OFS_PORT_CONTROL, 32'h0000_8101);
    send(8'h3c);
    step(400);
    chk({pcount, txd}, 9'h003);
    allow = 1'b1;
    wait_peer(8'h02);
    chk(pbyte, 8'h3c);
    // Nine zero bits: 3/16 of a 32-cycle bit is six cycles; in low-power
    // mode a tick every cycle gives three cycles per pulse.
    for (int m = 0; m < 2; m++)
    begin
      lp_tick = 1'(m);
      wr(OFS_PORT_CONTROL, 32'h0000_0103 | 32'(m * 4));
      send(8'h00);
      hi = 0;
      mark = 1'b1;
      for (int i = 0; i < 400; i++)
      begin
        step(1);
        hi += (ir_tx === 1'b1);
        mark &= txd;
      end
      chk(hi, m ? 27 : 54);
      chk(mark, 1'b1);
    end
  endtask

  // ==========================================================================
  // Main sequence and verdict
  // ==========================================================================
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    {psel, penable, pwrite, tx_valid, rx_wr, rx_rd} = 6'h00;
    {brk, par, frm, ovr, tick, rx_busy, lp_tick} = 7'h00;
    {rxd, ir_rx} = 2'h3;
    {paddr, pwdata, tx_data} = 48'h0000_0000_0000;
    {tx_cnt, rx_cnt, modem_n, allow} = {6'h00, 6'h00, 3'h7, 1'b1};
    fails = 0;
    num_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_ctrl();
    t_status();
    t_level();
    t_tx();
    test_done();
  end
endmodule // uart_ctl_tb
`default_nettype wire
